//--- dv/apm_aux_pin_mux_ctrl_tb.sv
// Self-checking bench for the auxiliary pin mux and control block
`timescale 1ns/10ps
module apm_aux_pin_mux_ctrl_tb;
    import apm_pkg::*;
    logic clk_sys, rst_n, wr, miso, sync, prst_n, exempt, mute_n, hiz;
    logic [7:0] addr, wdata, rdata;
    logic [4:0] src;
    logic [2:0] pin_o, pin_en, pin_i, ext_val, ext_en;
    int fail_count, compares;
    apm_aux_pin_mux_ctrl dut (.CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RDATA_O(rdata), .WARNING_N_I(src[0]),
        .FAULT_N_I(src[2]), .SERIAL_AUDIO_OUT_I(src[1]), .SUPPLY_DROP_I(src[3]),
        .CLASS_H_CTRL_I(src[4]), .AUX_PIN_ONE_I(pin_i[0]), .AUX_PIN_TWO_I(pin_i[1]),
        .AUX_PIN_ZERO_I(pin_i[2]), .AUX_PIN_ONE_O(pin_o[0]), .AUX_PIN_TWO_O(pin_o[1]),
        .AUX_PIN_ZERO_O(pin_o[2]), .PIN_ONE_DRIVE_EN_O(pin_en[0]),
        .PIN_TWO_DRIVE_EN_O(pin_en[1]), .PIN_ZERO_DRIVE_EN_O(pin_en[2]),
        .SPI_MISO_SRC_O(miso), .PHASE_SYNC_O(sync), .PIN_RESET_N_O(prst_n),
        .PIN_ZERO_RESET_EXEMPT_O(exempt), .MUTE_N_O(mute_n), .AMP_HIZ_O(hiz));
    apm_pin_partner board (.clk_i(clk_sys), .dev_val_i(pin_o), .dev_en_i(pin_en),
        .ext_val_i(ext_val), .ext_en_i(ext_en), .wire_o(pin_i));
    // Clock at 200 MHz
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // All stimulus moves 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            #1;
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
        // Idle edge so a following write never re-raises the strobe in this time step
        step(1);
    endtask
    // Read data is registered, so it is judged one edge after the address
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        step(1);
        chk("rdata", rdata, exp);
    endtask
    function automatic logic exp_fn(input logic [3:0] c, input logic [4:0] s, input logic ov);
        case (c)
            4'h0: return 1'b0;
            4'h8: return s[0];
            4'h9: return s[1];
            4'hb: return s[2];
            4'hc: return s[3];
            4'hd: return s[4];
            default: return ov;
        endcase
    endfunction
    task automatic t_reset();
        for (int a = 0; a < 8; a++) rd_chk(8'h60 + 8'(a), RESET_VAL);
        chk("idle", {pin_en, pin_o, miso, sync}, 8'h00);
        chk("idle_in", {prst_n, mute_n, hiz, exempt}, 8'h0c);
        $display("test reset done");
    endtask
    task automatic t_regs();
        logic [7:0] mask [7] = '{8'h07, 8'h0f, 8'h0f, 8'h0f, 8'hff, 8'h07, 8'h07};
        for (int a = 0; a < 7; a++) begin
            wr_reg(8'h60 + 8'(a), 8'hff);
            rd_chk(8'h60 + 8'(a), mask[a]);
            wr_reg(8'h60 + 8'(a), 8'h00);
        end
        wr_reg(8'h67, 8'ha5);
        rd_chk(8'h67, READ_UNMAPPED);
        $display("test registers done");
    endtask
    // Every listed code plus one unlisted code, both source patterns, both inversions
    task automatic t_func();
        logic [3:0] codes [7] = '{4'h0, 4'h8, 4'h9, 4'hb, 4'hc, 4'hd, 4'h3};
        logic [4:0] pats [2] = '{5'h15, 5'h0a};
        wr_reg(ADDR_DIR, 8'h01);
        wr_reg(ADDR_OUT_VAL, 8'h01);
        for (int c = 0; c < 7; c++) begin
            for (int i = 0; i < 4; i++) begin
                wr_reg(ADDR_FUNC_ONE, {4'h0, codes[c]});
                wr_reg(ADDR_OUT_INV, {7'h00, i[1]});
                src = pats[i[0]];
                step(2);
                chk("pin_one", {7'h00, pin_o[0]}, {7'h00, exp_fn(codes[c], src, 1'b1) ^ i[1]});
            end
        end
        wr_reg(ADDR_DIR, 8'h00);
        step(2);
        chk("pin_off", {6'h00, pin_en[0], pin_o[0]}, 8'h00);
        $display("test functions done");
    endtask
    // Bit order of direction, function, output value and invert registers
    task automatic t_pins();
        src = 5'h01;
        wr_reg(ADDR_OUT_INV, 8'h00);
        for (int p = 0; p < 3; p++) begin
            wr_reg(ADDR_DIR, 8'h01 << p);
            wr_reg(ADDR_FUNC_ONE + 8'(p), 8'h08);
            step(2);
            chk("pin_en", {5'h00, pin_en}, 8'h01 << p);
            chk("pin_o", {5'h00, pin_o}, 8'h01 << p);
            wr_reg(ADDR_FUNC_ONE + 8'(p), 8'h01);
        end
        wr_reg(ADDR_DIR, 8'h07);
        wr_reg(ADDR_OUT_VAL, 8'h05);
        wr_reg(ADDR_OUT_INV, 8'h03);
        step(2);
        chk("pin_sw", {5'h00, pin_o}, 8'h06);
        wr_reg(ADDR_DIR, 8'h00);
        $display("test pin order done");
    endtask
    // Each selector, each code, two board patterns
    task automatic t_route();
        logic lvl;
        logic [7:0] seen;
        ext_en = 3'h7;
        for (int f = 0; f < 4; f++) begin
            for (int c = 0; c < 4; c++) begin
                wr_reg(ADDR_IN_ROUTE, 8'(c) << (6 - 2 * f));
                for (int k = 0; k < 2; k++) begin
                    ext_val = k[0] ? 3'h2 : 3'h5;
                    step(2);
                    lvl = (c == 0) ? (f >= 2) : ext_val[c - 1];
                    seen = {7'h00, f == 0 ? miso : f == 1 ? sync : f == 2 ? prst_n : mute_n};
                    chk("route", seen, {7'h00, lvl});
                    if (f == 3) chk("hiz", {7'h00, hiz}, {7'h00, ~lvl});
                    if (f == 2) chk("exempt", {7'h00, exempt}, {7'h00, c == 3});
                end
            end
        end
        wr_reg(ADDR_IN_ROUTE, 8'h00);
        $display("test routing done");
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Watchdog cuts a hang short
    initial begin
        #200000;
        fail_count++;
        final_report();
    end
    initial begin
        {rst_n, wr, addr, wdata, src, ext_val, ext_en} = '0;
        fail_count = 0;
        compares = 0;
        repeat (16) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_regs();
        t_func();
        t_pins();
        t_route();
        final_report();
    end
endmodule // apm_aux_pin_mux_ctrl_tb

//--- dv/apm_pin_partner.sv
// Board-side model of the three auxiliary pins
`timescale 1ns/10ps
module apm_pin_partner (
    // Clock
    input wire logic clk_i,
    // Device side, bit 0 pin one, bit 1 pin two, bit 2 pin zero
    input wire logic [2:0] dev_val_i,
    input wire logic [2:0] dev_en_i,
    // Board drivers
    input wire logic [2:0] ext_val_i,
    input wire logic [2:0] ext_en_i,
    // Resolved wire levels
    output logic [2:0] wire_o
);
    logic [2:0] float_lvl = 3'h5;
    // Undriven lines wander so a stale level never passes for a real one
    always_ff @(posedge clk_i) begin
        float_lvl <= ~float_lvl;
    end
    // Device driver first, then the board, which may hold a mute source low
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            wire_o[i] = dev_en_i[i] ? dev_val_i[i] : (ext_en_i[i] ? ext_val_i[i] : float_lvl[i]);
        end
    end
endmodule // apm_pin_partner

//--- hdl/apm_aux_pin_mux_ctrl.sv
// Auxiliary pin direction, output function mux and input routing
// Functional notes
// [RULE_01] Direction bits at 0x60, one per pin
// [RULE_02] Direction resets clear; reserved bits zero
// [RULE_03] Per-pin four-bit function select at 0x61-0x63
// [RULE_04] Code 0000 drives pin low; reset value
// [RULE_05] Code 1000 drives active-low warning
// [RULE_06] Code 1001 drives serial audio data out
// [RULE_07] Code 1011 drives active-low fault
// [RULE_08] Code 1100 drives supply drop flag
// [RULE_09] Code 1101 drives class-H control
// [RULE_10] Register 0x64 routes pins to four inputs
// [RULE_11] Reset routed from pin zero spares it
// [RULE_12] Mute source low forces high impedance, no switching
// [RULE_13] Output value bits at 0x65, reset zero
// [RULE_14] Invert bits at 0x66, same order
// [RULE_15] Pin drives only while direction bit set
// [RULE_16] Driven level is source XOR invert bit
`timescale 1ns/10ps
module apm_aux_pin_mux_ctrl
    import apm_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    // Register port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    output logic [7:0] REG_RDATA_O,
    // Internal function sources
    input wire logic WARNING_N_I,
    input wire logic FAULT_N_I,
    input wire logic SERIAL_AUDIO_OUT_I,
    input wire logic SUPPLY_DROP_I,
    input wire logic CLASS_H_CTRL_I,
    // Pins, split into input, output and enable
    input wire logic AUX_PIN_ONE_I,
    input wire logic AUX_PIN_TWO_I,
    input wire logic AUX_PIN_ZERO_I,
    output logic AUX_PIN_ONE_O,
    output logic AUX_PIN_TWO_O,
    output logic AUX_PIN_ZERO_O,
    output logic PIN_ONE_DRIVE_EN_O,
    output logic PIN_TWO_DRIVE_EN_O,
    output logic PIN_ZERO_DRIVE_EN_O,
    // Routed internal inputs
    output logic SPI_MISO_SRC_O,
    output logic PHASE_SYNC_O,
    output logic PIN_RESET_N_O,
    output logic PIN_ZERO_RESET_EXEMPT_O,
    output logic MUTE_N_O,
    output logic AMP_HIZ_O
);

    logic [2:0] dir;
    logic [3:0] func [3];
    logic [7:0] route;
    logic [2:0] out_val;
    logic [2:0] out_inv;
    logic [2:0] pin_out;
    logic [2:0] pin_oe;
    logic [7:0] rd_data;
    logic miso;
    logic sync;
    logic rst_n;
    logic rst_exempt;
    logic mute_n;
    logic hiz;

    logic [2:0] next_dir;
    logic [3:0] next_func [3];
    logic [7:0] next_route;
    logic [2:0] next_out_val;
    logic [2:0] next_out_inv;
    logic [2:0] next_pin_out;
    logic [2:0] next_pin_oe;
    logic [7:0] next_rd_data;
    logic next_miso;
    logic next_sync;
    logic next_rst_n;
    logic next_rst_exempt;
    logic next_mute_n;
    logic next_hiz;
    logic [2:0] pin_in;

    assign pin_in = {AUX_PIN_ZERO_I, AUX_PIN_TWO_I, AUX_PIN_ONE_I};

    // Pick the level of an output function; unlisted codes fall back to software value
    function automatic logic func_level(input logic [3:0] code, input logic sw_val);
        case (code)
            FN_OFF: func_level = 1'b0; // [RULE_04]
            FN_WARNING: func_level = WARNING_N_I; // [RULE_05]
            FN_SERIAL_OUT: func_level = SERIAL_AUDIO_OUT_I; // [RULE_06]
            FN_FAULT: func_level = FAULT_N_I; // [RULE_07]
            FN_SUPPLY_DROP: func_level = SUPPLY_DROP_I; // [RULE_08]
            FN_CLASS_H: func_level = CLASS_H_CTRL_I; // [RULE_09]
            default: func_level = sw_val;
        endcase
    endfunction

    // Select a pin for a routed input; no pin gives the idle level
    function automatic logic route_pin(input logic [1:0] sel, input logic idle);
        case (sel)
            SRC_PIN_ONE: route_pin = pin_in[BIT_PIN_ONE];
            SRC_PIN_TWO: route_pin = pin_in[BIT_PIN_TWO];
            SRC_PIN_ZERO: route_pin = pin_in[BIT_PIN_ZERO];
            default: route_pin = idle;
        endcase
    endfunction

    // Register writes; reserved bits are not stored and read as zero
    always_comb begin
        next_dir = dir;
        next_func = func;
        next_route = route;
        next_out_val = out_val;
        next_out_inv = out_inv;
        if (REG_WR_I) begin
            case (REG_ADDR_I)
                ADDR_DIR: next_dir = REG_WDATA_I[2:0]; // [RULE_01]
                ADDR_FUNC_ONE: next_func[BIT_PIN_ONE] = REG_WDATA_I[3:0]; // [RULE_03]
                ADDR_FUNC_TWO: next_func[BIT_PIN_TWO] = REG_WDATA_I[3:0]; // [RULE_03]
                ADDR_FUNC_ZERO: next_func[BIT_PIN_ZERO] = REG_WDATA_I[3:0]; // [RULE_03]
                ADDR_IN_ROUTE: next_route = REG_WDATA_I; // [RULE_10]
                ADDR_OUT_VAL: next_out_val = REG_WDATA_I[2:0]; // [RULE_13]
                ADDR_OUT_INV: next_out_inv = REG_WDATA_I[2:0]; // [RULE_14]
                default: next_dir = dir;
            endcase
        end
    end

    // Read data, registered so the port comes from a flop
    always_comb begin
        case (REG_ADDR_I)
            ADDR_DIR: next_rd_data = {5'h00, dir}; // [RULE_02]
            ADDR_FUNC_ONE: next_rd_data = {4'h0, func[BIT_PIN_ONE]};
            ADDR_FUNC_TWO: next_rd_data = {4'h0, func[BIT_PIN_TWO]};
            ADDR_FUNC_ZERO: next_rd_data = {4'h0, func[BIT_PIN_ZERO]};
            ADDR_IN_ROUTE: next_rd_data = route;
            ADDR_OUT_VAL: next_rd_data = {5'h00, out_val};
            ADDR_OUT_INV: next_rd_data = {5'h00, out_inv};
            default: next_rd_data = READ_UNMAPPED;
        endcase
    end

    // Pin drive: enable follows direction, level is source XOR invert
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            next_pin_oe[i] = dir[i]; // [RULE_15]
            next_pin_out[i] = dir[i] & (func_level(func[i], out_val[i]) ^ out_inv[i]); // [RULE_16]
        end
    end

    // Input routing; reset and mute idle high so no pin means inactive
    always_comb begin
        next_miso = route_pin(route[POS_MISO +: 2], 1'b0); // [RULE_10]
        next_sync = route_pin(route[POS_SYNC +: 2], 1'b0); // [RULE_10]
        next_rst_n = route_pin(route[POS_RESET +: 2], 1'b1); // [RULE_10]
        // Pin zero logic must survive a reset that comes in through it
        next_rst_exempt = (route[POS_RESET +: 2] == SRC_PIN_ZERO); // [RULE_11]
        next_mute_n = route_pin(route[POS_MUTE +: 2], 1'b1);
        next_hiz = ~next_mute_n; // [RULE_12]
    end

    // State registers
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            dir <= RESET_VAL[2:0]; // [RULE_02]
            for (int i = 0; i < 3; i++) begin
                func[i] <= RESET_VAL[3:0]; // [RULE_04]
            end
            route <= RESET_VAL;
            out_val <= RESET_VAL[2:0]; // [RULE_13]
            out_inv <= RESET_VAL[2:0];
            pin_out <= 3'h0;
            pin_oe <= 3'h0;
            rd_data <= RESET_VAL;
            miso <= 1'b0;
            sync <= 1'b0;
            rst_n <= 1'b1;
            rst_exempt <= 1'b0;
            mute_n <= 1'b1;
            hiz <= 1'b0;
        end else begin
            dir <= next_dir;
            func <= next_func;
            route <= next_route;
            out_val <= next_out_val;
            out_inv <= next_out_inv;
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            rd_data <= next_rd_data;
            miso <= next_miso;
            sync <= next_sync;
            rst_n <= next_rst_n;
            rst_exempt <= next_rst_exempt;
            mute_n <= next_mute_n;
            hiz <= next_hiz;
        end
    end

    // Port drive straight from flops
    assign REG_RDATA_O = rd_data;
    assign AUX_PIN_ONE_O = pin_out[BIT_PIN_ONE];
    assign AUX_PIN_TWO_O = pin_out[BIT_PIN_TWO];
    assign AUX_PIN_ZERO_O = pin_out[BIT_PIN_ZERO];
    assign PIN_ONE_DRIVE_EN_O = pin_oe[BIT_PIN_ONE];
    assign PIN_TWO_DRIVE_EN_O = pin_oe[BIT_PIN_TWO];
    assign PIN_ZERO_DRIVE_EN_O = pin_oe[BIT_PIN_ZERO];
    assign SPI_MISO_SRC_O = miso;
    assign PHASE_SYNC_O = sync;
    assign PIN_RESET_N_O = rst_n;
    assign PIN_ZERO_RESET_EXEMPT_O = rst_exempt;
    assign MUTE_N_O = mute_n;
    assign AMP_HIZ_O = hiz;

    // Checks on the pin one path, the input routing and the register file
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);

    sequence s_dir_write;
        REG_WR_I && REG_ADDR_I == ADDR_DIR;
    endsequence

    a_dir_write_reads: assert property ( // [RULE_01]
        s_dir_write ##1 (REG_ADDR_I == ADDR_DIR) |=>
        REG_RDATA_O == {5'h00, $past(REG_WDATA_I[2:0], 2)})
        else $error("direction write not read back");
    a_dir_reserved_zero: assert property ( // [RULE_02]
        ##1 $past(REG_ADDR_I) == ADDR_DIR |-> REG_RDATA_O[7:3] == 5'h00)
        else $error("direction reserved bits not zero");
    a_func_reserved_zero: assert property ( // [RULE_03]
        ##1 $past(REG_ADDR_I) == ADDR_FUNC_ONE |-> REG_RDATA_O[7:4] == 4'h0)
        else $error("function reserved bits not zero");
    a_pin_oe_dir: assert property ( // [RULE_15]
        ##1 PIN_ONE_DRIVE_EN_O == $past(dir[0]))
        else $error("pin one enable not following direction");
    a_off_low: assert property ( // [RULE_04]
        dir[0] && func[0] == FN_OFF |=> AUX_PIN_ONE_O == $past(out_inv[0]))
        else $error("off code not driving low");
    a_warn_sel: assert property ( // [RULE_05]
        dir[0] && func[0] == FN_WARNING |=>
        AUX_PIN_ONE_O == ($past(WARNING_N_I) ^ $past(out_inv[0])))
        else $error("warning not on pin one");
    a_serial_sel: assert property ( // [RULE_06]
        dir[0] && func[0] == FN_SERIAL_OUT |=>
        AUX_PIN_ONE_O == ($past(SERIAL_AUDIO_OUT_I) ^ $past(out_inv[0])))
        else $error("serial data not on pin one");
    a_fault_sel: assert property ( // [RULE_07]
        dir[0] && func[0] == FN_FAULT |=>
        AUX_PIN_ONE_O == ($past(FAULT_N_I) ^ $past(out_inv[0])))
        else $error("fault not on pin one");
    a_drop_sel: assert property ( // [RULE_08]
        dir[0] && func[0] == FN_SUPPLY_DROP |=>
        AUX_PIN_ONE_O == ($past(SUPPLY_DROP_I) ^ $past(out_inv[0])))
        else $error("supply drop not on pin one");
    a_classh_sel: assert property ( // [RULE_09]
        dir[0] && func[0] == FN_CLASS_H |=>
        AUX_PIN_ONE_O == ($past(CLASS_H_CTRL_I) ^ $past(out_inv[0])))
        else $error("class-H not on pin one");
    a_miso_route: assert property ( // [RULE_10]
        route[POS_MISO +: 2] == SRC_PIN_TWO |=> SPI_MISO_SRC_O == $past(AUX_PIN_TWO_I))
        else $error("miso routing wrong");
    a_reset_pin_zero: assert property ( // [RULE_11]
        route[POS_RESET +: 2] == SRC_PIN_ZERO |=>
        PIN_ZERO_RESET_EXEMPT_O && PIN_RESET_N_O == $past(AUX_PIN_ZERO_I))
        else $error("pin zero reset routing wrong");
    a_mute_hiz: assert property ( // [RULE_12]
        route[POS_MUTE +: 2] == SRC_PIN_ONE && !AUX_PIN_ONE_I |=> AMP_HIZ_O && !MUTE_N_O)
        else $error("mute low did not force high impedance");
    a_outval_drive: assert property ( // [RULE_13] [RULE_14]
        dir[0] && func[0] == 4'h1 |=>
        AUX_PIN_ONE_O == ($past(out_val[0]) ^ $past(out_inv[0])))
        else $error("software value not on pin one");
    a_input_no_drive: assert property ( // [RULE_15]
        !dir[0] |=> !AUX_PIN_ONE_O)
        else $error("input pin driving level");

    // Same function mux on pins two and zero, checked with the warning source, then drive enable bit order
    a_pin_two_warn: assert property ( // [RULE_03] [RULE_05]
        dir[BIT_PIN_TWO] && func[BIT_PIN_TWO] == FN_WARNING |=>
        AUX_PIN_TWO_O == ($past(WARNING_N_I) ^ $past(out_inv[BIT_PIN_TWO])))
        else $error("warning not on pin two");
    a_pin_zero_warn: assert property ( // [RULE_03] [RULE_05]
        dir[BIT_PIN_ZERO] && func[BIT_PIN_ZERO] == FN_WARNING |=>
        AUX_PIN_ZERO_O == ($past(WARNING_N_I) ^ $past(out_inv[BIT_PIN_ZERO])))
        else $error("warning not on pin zero");
    a_enable_order: assert property ( // [RULE_01] [RULE_15]
        ##1 {PIN_ZERO_DRIVE_EN_O, PIN_TWO_DRIVE_EN_O, PIN_ONE_DRIVE_EN_O} == $past(dir))
        else $error("drive enables out of bit order");

    // Unrouted miso and reset sit inactive, so a stray pin can never reset the part; then phase sync routing and mute release
    a_miso_idle: assert property ( // [RULE_10]
        route[POS_MISO +: 2] == SRC_NONE |=> !SPI_MISO_SRC_O)
        else $error("unrouted miso not low");
    a_reset_idle: assert property ( // [RULE_11]
        route[POS_RESET +: 2] == SRC_NONE |=> PIN_RESET_N_O && !PIN_ZERO_RESET_EXEMPT_O)
        else $error("unrouted reset not inactive");
    a_sync_route: assert property ( // [RULE_10]
        route[POS_SYNC +: 2] == SRC_PIN_ZERO |=> PHASE_SYNC_O == $past(AUX_PIN_ZERO_I))
        else $error("phase sync routing wrong");
    a_mute_release: assert property ( // [RULE_12]
        route[POS_MUTE +: 2] == SRC_PIN_ZERO && AUX_PIN_ZERO_I |=> !AMP_HIZ_O && MUTE_N_O)
        else $error("mute high did not release the output stage");

    // Writes land in the addressed register
    sequence s_route_write;
        REG_WR_I && REG_ADDR_I == ADDR_IN_ROUTE;
    endsequence
    a_route_reads: assert property ( // [RULE_10]
        s_route_write ##1 (REG_ADDR_I == ADDR_IN_ROUTE) |=>
        REG_RDATA_O == $past(REG_WDATA_I, 2))
        else $error("routing write not read back");
    a_func_zero_write: assert property ( // [RULE_03]
        REG_WR_I && REG_ADDR_I == ADDR_FUNC_ZERO |=>
        func[BIT_PIN_ZERO] == $past(REG_WDATA_I[3:0]))
        else $error("pin zero function write lost");
    a_outval_write: assert property ( // [RULE_13]
        REG_WR_I && REG_ADDR_I == ADDR_OUT_VAL |=> out_val == $past(REG_WDATA_I[2:0]))
        else $error("output value write lost");
    a_invert_write: assert property ( // [RULE_14]
        REG_WR_I && REG_ADDR_I == ADDR_OUT_INV |=> out_inv == $past(REG_WDATA_I[2:0]))
        else $error("invert write lost");

endmodule // apm_aux_pin_mux_ctrl

//--- include/apm_pkg.sv
// Constants for the auxiliary pin mux and control block
package apm_pkg;
    localparam logic [7:0] ADDR_DIR = 8'h60;
    localparam logic [7:0] ADDR_FUNC_ONE = 8'h61;
    localparam logic [7:0] ADDR_FUNC_TWO = 8'h62;
    localparam logic [7:0] ADDR_FUNC_ZERO = 8'h63;
    localparam logic [7:0] ADDR_IN_ROUTE = 8'h64;
    localparam logic [7:0] ADDR_OUT_VAL = 8'h65;
    localparam logic [7:0] ADDR_OUT_INV = 8'h66;
    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    // Pin bit order in per-pin registers
    localparam int BIT_PIN_ONE = 0;
    localparam int BIT_PIN_TWO = 1;
    localparam int BIT_PIN_ZERO = 2;
    // Routing field positions (low bit of each two-bit field)
    localparam int POS_MISO = 6;
    localparam int POS_SYNC = 4;
    localparam int POS_RESET = 2;
    localparam int POS_MUTE = 0;
    // Routing codes
    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_PIN_ONE = 2'b01,
        SRC_PIN_TWO = 2'b10,
        SRC_PIN_ZERO = 2'b11
    } apm_src_t;
    // Output function codes
    typedef enum logic [3:0] {
        FN_OFF = 4'h0,
        FN_WARNING = 4'h8,
        FN_SERIAL_OUT = 4'h9,
        FN_FAULT = 4'hb,
        FN_SUPPLY_DROP = 4'hc,
        FN_CLASS_H = 4'hd
    } apm_func_t;
endpackage
